/* File: include/gtc_pkg.sv */
// Package: register map, fields and types of the gated 16-bit timer
// Operation
// - Count byte reads stay valid and stable even with an asynchronous count clock.
// - Gate source selects between gate pin (or alternate) and comparator output.
// - Timer off ignores gate enable; on with gate enable counts only when gated.
// - Gate polarity applies to both sources; set means active high.
// - Counter wraps from all ones to zero and sets the overflow flag.
// - Interrupt needs flag, own enable, peripheral and global enables; write zero clears.
// - Sleep counting only in async external mode; overflow wakes; vector needs global.
// - Capture event copies the full 16-bit count into the capture pair.
// - Compare event fires when the compare pair equals the count.
// - Special event trigger clears the count without setting the overflow flag.
// - A count byte write in the same cycle as a trigger clear wins.
// - Comparator output may be synchronized to the counter increment clock.
// - External mode needs a falling edge before the first counted rising edge.
// - Prescale field divides by one, two, four or eight.
// - Low-power oscillator enable acts only in internal-oscillator-no-output mode.
// - Sync disable bypasses external clock synchronisation; ignored for internal source.
// - Source bit set counts external pin rising edges, else internal clock.
// - Timer-on enables counting; clearing it stops and keeps the value.
// - Count byte write loads that byte and clears the prescale counter.
// - Alternate clock select picks system clock over instruction clock, internal only.
package gtc_pkg;
  localparam logic [11:0] OFS_COUNT_LOW = 12'h000;
  localparam logic [11:0] OFS_COUNT_HIGH = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h008;
  localparam logic [11:0] OFS_AUX_CONTROL = 12'h00c;
  localparam logic [11:0] OFS_IRQ = 12'h010;
  localparam logic [11:0] OFS_CAPCMP = 12'h014;
  localparam logic [11:0] OFS_CAPCMP_CTRL = 12'h018;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [15:0] CAPCMP_RESET = 16'h0000;
  localparam logic [1:0] CCMODE_RESET = 2'h0;
  localparam int BIT_TIMER_ON = 0;
  localparam int BIT_CLK_SRC = 1;
  localparam int BIT_SYNC_DIS = 2;
  localparam int BIT_LPOSC_EN = 3;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_GATE_EN = 6;
  localparam int BIT_GATE_POL = 7;
  localparam int BIT_GATE_SRC = 0;
  localparam int BIT_ALT_CLK = 1;
  localparam int BIT_CMP_SYNC = 2;
  localparam int BIT_GATE_ALT = 3;
  localparam int BIT_INTERNAL_OSCILLATOR_MODE = 4;
  localparam int BIT_SLEEP = 5;
  localparam int BIT_OVF_FLAG = 0;
  localparam int BIT_OVF_IE = 1;
  localparam int BIT_PERIPH_IE = 2;
  localparam int BIT_GLOBAL_IE = 3;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  typedef enum logic [1:0] {CC_OFF, CC_CAPTURE, CC_COMPARE, CC_SPECIAL}
    gtc_ccmode_e;

  typedef struct packed {
    logic gate_polarity;
    logic gate_enable;
    logic [1:0] prescale_select;
    logic lowpower_osc_enable;
    logic sync_disable;
    logic clock_source_select;
    logic timer_on;
  } gtc_control_s;

  typedef struct packed {
    logic gate_pin;
    logic gate_pin_alt;
    logic comparator_output;
    logic count_input_pin;
    logic capture_event;
  } gtc_inputs_s;

  typedef struct packed {
    logic irq;
    logic wake;
    logic lowpower_osc_on;
    logic compare_event;
  } gtc_events_s;
endpackage

/* File: rtl/gtc_timer.sv */
// Gated 16-bit timer/counter with APB registers and capture/compare base
`timescale 1ns/1ps
module gtc_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and partner signals
  input wire gtc_pkg::gtc_inputs_s pins,
  output gtc_pkg::gtc_events_s events
);
  import gtc_pkg::*;

  gtc_control_s ctl_r;
  logic [7:0] aux_r;
  logic [3:0] irq_r;
  logic [15:0] count_r;
  logic [15:0] capcmp_r;
  logic [1:0] ccmode_r;
  logic [2:0] pre_r;
  logic [1:0] instr_div_r;
  logic [2:0] sync_cki_r;
  logic [2:0] sync_gp_r;
  logic [2:0] sync_ga_r;
  logic [2:0] sync_cmp_r;
  logic [2:0] sync_cap_r;
  logic cki_lvl_r;
  logic gp_lvl_r;
  logic ga_lvl_r;
  logic cmp_lvl_r;
  logic cap_lvl_r;
  logic cmp_held_r;
  logic armed_r;
  logic cmp_evt_r;
  logic special_clr_r;

  // Three-stage filter: level moves once stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  function automatic logic [2:0] pre_mask(input logic [1:0] sel);
    pre_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // One register's write strobe
  function automatic logic wr_hit(input logic w, input logic [11:0] a,
    input logic [11:0] ofs);
    wr_hit = w & (a == ofs);
  endfunction

  logic wr;
  logic rd;
  logic wr_low;
  logic wr_high;
  logic cki_n;
  logic cki_rise;
  logic cki_fall;
  logic cki_raw_rise;
  logic tick_src;
  logic gate_raw;
  logic gate_ok;
  logic count_en;
  logic tick;
  logic inc;
  logic [15:0] count_nxt;
  logic wr_ctl;
  logic wr_aux;
  logic wr_mode;
  logic wr_capcmp;
  logic wr_irq;
  logic count_wr;
  logic cap_rise;
  logic ovf_wrap;
  logic ovf_armed;

  assign wr = psel & penable & pwrite & clk_en;
  assign rd = psel & ~pwrite;
  assign wr_low = wr_hit(wr, paddr, OFS_COUNT_LOW);
  assign wr_high = wr_hit(wr, paddr, OFS_COUNT_HIGH);
  assign wr_ctl = wr_hit(wr, paddr, OFS_CONTROL);
  assign wr_aux = wr_hit(wr, paddr, OFS_AUX_CONTROL);
  assign wr_mode = wr_hit(wr, paddr, OFS_CAPCMP_CTRL);
  assign wr_capcmp = wr_hit(wr, paddr, OFS_CAPCMP);
  assign wr_irq = wr_hit(wr, paddr, OFS_IRQ);
  assign count_wr = wr_low | wr_high;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Input synchronisers; every count byte read sees a pclk-domain value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cki_r <= 3'h0;
      sync_gp_r <= 3'h0;
      sync_ga_r <= 3'h0;
      sync_cmp_r <= 3'h0;
      sync_cap_r <= 3'h0;
    end else if (clk_en) begin
      sync_cki_r <= {sync_cki_r[1:0], pins.count_input_pin};
      sync_gp_r <= {sync_gp_r[1:0], pins.gate_pin};
      sync_ga_r <= {sync_ga_r[1:0], pins.gate_pin_alt};
      sync_cmp_r <= {sync_cmp_r[1:0], pins.comparator_output};
      sync_cap_r <= {sync_cap_r[1:0], pins.capture_event};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cki_lvl_r <= 1'b0;
      gp_lvl_r <= 1'b0;
      ga_lvl_r <= 1'b0;
      cmp_lvl_r <= 1'b0;
      cap_lvl_r <= 1'b0;
    end else if (clk_en) begin
      cki_lvl_r <= filt(sync_cki_r, cki_lvl_r);
      gp_lvl_r <= filt(sync_gp_r, gp_lvl_r);
      ga_lvl_r <= filt(sync_ga_r, ga_lvl_r);
      cmp_lvl_r <= filt(sync_cmp_r, cmp_lvl_r);
      cap_lvl_r <= filt(sync_cap_r, cap_lvl_r);
    end
  end

  assign cki_n = filt(sync_cki_r, cki_lvl_r);
  assign cki_rise = cki_n & ~cki_lvl_r;
  assign cki_fall = ~cki_n & cki_lvl_r;
  // Unsynchronised path: agreement of stages two and three only
  assign cki_raw_rise = sync_cki_r[1] & sync_cki_r[2] & ~cki_lvl_r;
  assign cap_rise = filt(sync_cap_r, cap_lvl_r) & ~cap_lvl_r;

  // Instruction clock: one in four system clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div_r <= 2'h0;
    end else if (clk_en) begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  // Arming for the first counted rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_low || wr_high || !ctl_r.timer_on) begin
        armed_r <= armed_r & ~(wr_low | wr_high) & ~cki_lvl_r;
      end else if (cki_fall) begin
        armed_r <= 1'b1;
      end
    end
  end

  always_comb begin
    if (ctl_r.clock_source_select) begin
      if (ctl_r.sync_disable) begin
        tick_src = cki_raw_rise & armed_r;
      end else begin
        tick_src = cki_rise & armed_r;
      end
    end else if (aux_r[BIT_ALT_CLK]) begin
      tick_src = 1'b1;
    end else begin
      tick_src = (instr_div_r == INSTR_DIV_LAST);
    end
  end

  // Comparator held on the increment clock when sync is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_held_r <= 1'b0;
    end else if (clk_en && (tick_src || !aux_r[BIT_CMP_SYNC])) begin
      cmp_held_r <= cmp_lvl_r;
    end
  end

  always_comb begin
    if (aux_r[BIT_GATE_SRC]) begin
      gate_raw = cmp_held_r;
    end else begin
      gate_raw = aux_r[BIT_GATE_ALT] ? ga_lvl_r : gp_lvl_r;
    end
  end

  assign gate_ok = ctl_r.gate_polarity ? gate_raw : ~gate_raw;
  assign count_en = ctl_r.timer_on &
    (~ctl_r.gate_enable | gate_ok);
  assign tick = count_en & tick_src &
    (~aux_r[BIT_SLEEP] | (ctl_r.clock_source_select &
    ctl_r.sync_disable));
  assign inc = tick & ((pre_r & pre_mask(ctl_r.prescale_select)) ==
    pre_mask(ctl_r.prescale_select));
  // Wrap that sets the flag; a special clear never does
  assign ovf_wrap = inc & (count_r == COUNT_MAX) & ~special_clr_r;
  assign ovf_armed = irq_r[BIT_OVF_FLAG] & irq_r[BIT_OVF_IE] &
    irq_r[BIT_PERIPH_IE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 3'h0;
    end else if (clk_en) begin
      if (wr_low || wr_high) begin
        pre_r <= 3'h0;
      end else if (inc) begin
        pre_r <= 3'h0;
      end else if (tick) begin
        pre_r <= pre_r + 3'h1;
      end
    end
  end

  always_comb begin
    count_nxt = count_r;
    if (special_clr_r && !count_wr) begin
      count_nxt = 16'h0000;
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
    if (wr_low) begin
      count_nxt[7:0] = pwdata[7:0];
    end
    if (wr_high) begin
      count_nxt[15:8] = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 16'h0000;
    end else if (clk_en) begin
      count_r <= count_nxt;
    end
  end

  // Compare match as one pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_evt_r <= 1'b0;
    end else if (clk_en) begin
      cmp_evt_r <= (ccmode_r[1]) && (capcmp_r == count_r) &&
        (count_nxt != count_r);
    end
  end

  // Special mode clears the count on the cycle after the match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_clr_r <= 1'b0;
    end else if (clk_en) begin
      special_clr_r <= (ccmode_r == CC_SPECIAL) &&
        (capcmp_r == count_nxt) && (count_nxt != count_r);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= CONTROL_RESET;
    end else if (wr_ctl) begin
      ctl_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_r <= AUX_RESET;
    end else if (wr_aux) begin
      aux_r <= {2'h0, pwdata[5:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccmode_r <= CCMODE_RESET;
    end else if (wr_mode) begin
      ccmode_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capcmp_r <= CAPCMP_RESET;
    end else if (clk_en) begin
      if (wr_capcmp) begin
        capcmp_r <= pwdata[15:0];
      end else if (ccmode_r == CC_CAPTURE && cap_rise) begin
        capcmp_r <= count_r;
      end
    end
  end

  // Overflow flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 4'h0;
    end else if (clk_en) begin
      if (wr_irq) begin
        irq_r[3:1] <= pwdata[3:1];
      end
      if (ovf_wrap) begin
        irq_r[BIT_OVF_FLAG] <= 1'b1;
      end else if (wr_irq && !pwdata[BIT_OVF_FLAG]) begin
        irq_r[BIT_OVF_FLAG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && rd && !penable) begin
      unique case (paddr)
        OFS_COUNT_LOW: prdata <= {24'h0, count_r[7:0]};
        OFS_COUNT_HIGH: prdata <= {24'h0, count_r[15:8]};
        OFS_CONTROL: prdata <= {24'h0, ctl_r};
        OFS_AUX_CONTROL: prdata <= {24'h0, aux_r};
        OFS_IRQ: prdata <= {28'h0, irq_r};
        OFS_CAPCMP: prdata <= {16'h0, capcmp_r};
        OFS_CAPCMP_CTRL: prdata <= {30'h0, ccmode_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= '0;
    end else if (clk_en) begin
      events.irq <= ovf_armed & irq_r[BIT_GLOBAL_IE];
      events.wake <= ovf_armed & ctl_r.timer_on;
      events.lowpower_osc_on <= ctl_r.lowpower_osc_enable &
        aux_r[BIT_INTERNAL_OSCILLATOR_MODE];
      events.compare_event <= cmp_evt_r;
    end
  end
endmodule

/* File: bench/gtc_chk.sv */
// Checker watching the timer's top-level ports
`timescale 1ns/1ps
module gtc_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire gtc_pkg::gtc_inputs_s pins,
  input wire gtc_pkg::gtc_events_s events
);
  import gtc_pkg::*;
  logic [7:0] ctl_r;
  logic [7:0] aux_r;
  logic [3:1] ie_r;
  logic [1:0] mode_r;
  wire wr = psel && penable && pwrite && clk_en;
  wire rs = psel && !penable && !pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of written settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 8'h00;
      aux_r <= 8'h00;
      ie_r <= 3'h0;
      mode_r <= 2'h0;
    end else if (wr) begin
      if (paddr == OFS_CONTROL) ctl_r <= pwdata[7:0];
      if (paddr == OFS_AUX_CONTROL) aux_r <= pwdata[7:0];
      if (paddr == OFS_IRQ) ie_r <= pwdata[3:1];
      if (paddr == OFS_CAPCMP_CTRL) mode_r <= pwdata[1:0];
    end
  end
  chk_ready_high: assert property (pready && !pslverr)
    else $error("ready low or error raised");
  chk_ctl_read: assert property (
    rs && paddr == OFS_CONTROL |=> prdata[7:0] == ctl_r)
    else $error("control readback wrong");
  chk_unmapped_zero: assert property (
    rs && paddr == 12'h01c |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_lpo_follow: assert property (
    clk_en && $past(clk_en) |-> events.lowpower_osc_on ==
      $past(ctl_r[BIT_LPOSC_EN] & aux_r[BIT_INTERNAL_OSCILLATOR_MODE]))
    else $error("oscillator enable wrong");
  chk_irq_needs_en: assert property (
    $past(clk_en) && !$past(&ie_r) |-> !events.irq)
    else $error("irq without all enables");
  chk_wake_needs_on: assert property (
    $past(clk_en) && !$past(ctl_r[BIT_TIMER_ON] & ie_r[BIT_OVF_IE] &
      ie_r[BIT_PERIPH_IE]) |-> !events.wake)
    else $error("wake without enables");
  chk_irq_wake_pair: assert property (
    events.irq && $past(ctl_r[BIT_TIMER_ON]) |-> events.wake)
    else $error("irq without wake");
  chk_cmp_pulse: assert property (
    events.compare_event |=> !events.compare_event)
    else $error("compare event longer than a cycle");
  chk_cmp_mode: assert property (
    events.compare_event |-> $past(mode_r[1]) || $past(mode_r[1], 2))
    else $error("compare event outside compare modes");
endmodule
bind gtc_timer gtc_chk u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .events);

/* File: bench/gtc_far.sv */
// Far-side model: gate sources, count pin and capture event
`timescale 1ns/1ps
module gtc_far (
  // Clock
  input wire logic pclk,
  // Pins into the timer
  output gtc_pkg::gtc_inputs_s pins
);
  import gtc_pkg::*;
  initial pins = '0;
  // Levels change only after a clock edge
  task automatic set_lv(input logic [2:0] lv);
    @(posedge pclk);
    pins.gate_pin <= lv[2];
    pins.gate_pin_alt <= lv[1];
    pins.comparator_output <= lv[0];
  endtask
  // Count pin idles low between bursts
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (8) @(posedge pclk);
      pins.count_input_pin <= 1'b1;
      repeat (8) @(posedge pclk);
      pins.count_input_pin <= 1'b0;
    end
  endtask
  task automatic capture();
    @(posedge pclk);
    pins.capture_event <= 1'b1;
    repeat (8) @(posedge pclk);
    pins.capture_event <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule

/* File: bench/tb.sv */
// Testbench for the gated 16-bit timer
`timescale 1ns/1ps
module tb;
  import gtc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  gtc_inputs_s pins;
  gtc_events_s events;
  int err_total = 0;
  int checks = 0;
  logic [31:0] rv;
  always #50 pclk = ~pclk;
  gtc_timer u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .events);
  gtc_far u_far (.pclk, .pins);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Low-byte increase over exactly 64 cycles
  task automatic rate(input logic [7:0] exp);
    logic [7:0] a;
    repeat (8) @(posedge pclk);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    a = rv[7:0];
    repeat (61) @(posedge pclk);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    chk("count rate", {24'h0, rv[7:0] - a}, {24'h0, exp});
  endtask
  task automatic t_regs();
    apb(1'b0, OFS_CONTROL, 32'h0);
    chk("control reset", rv, {24'h0, CONTROL_RESET});
    apb(1'b1, 12'h01c, 32'hffffffff);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", rv, 32'h0);
    apb(1'b1, OFS_AUX_CONTROL, 32'h10);
    apb(1'b1, OFS_CONTROL, 32'h08);
    repeat (3) @(posedge pclk);
    chk("osc on", events.lowpower_osc_on, 32'h1);
    apb(1'b1, OFS_AUX_CONTROL, 32'h0);
    repeat (3) @(posedge pclk);
    chk("osc off", events.lowpower_osc_on, 32'h0);
    apb(1'b1, OFS_CONTROL, 32'h0);
  endtask
  task automatic t_rates();
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFS_AUX_CONTROL, {30'h0, s[0], 1'b0});
      for (int p = 0; p < 4; p++) begin
        apb(1'b1, OFS_CONTROL, {26'h0, p[1:0], 4'h1});
        rate(8'((s ? 64 : 16) >> p));
      end
    end
    apb(1'b1, OFS_CONTROL, 32'h0);
    rate(8'h0);
  endtask
  task automatic gcase(input logic [7:0] aux, ctl, input logic [2:0] lv,
    input logic [7:0] exp);
    u_far.set_lv(lv);
    apb(1'b1, OFS_AUX_CONTROL, {24'h0, aux});
    apb(1'b1, OFS_CONTROL, {24'h0, ctl});
    rate(exp);
  endtask
  task automatic t_gate();
    gcase(8'h02, 8'hc1, 3'b100, 8'd64);
    gcase(8'h02, 8'hc1, 3'b011, 8'd0);
    gcase(8'h02, 8'h41, 3'b011, 8'd64);
    gcase(8'h02, 8'h01, 3'b011, 8'd64);
    gcase(8'h07, 8'hc1, 3'b001, 8'd64);
    gcase(8'h07, 8'h41, 3'b001, 8'd0);
    gcase(8'h0a, 8'hc1, 3'b010, 8'd64);
    gcase(8'h02, 8'hc0, 3'b100, 8'd0);
  endtask
  task automatic t_ovf();
    apb(1'b1, OFS_CONTROL, 32'h0);
    apb(1'b1, OFS_AUX_CONTROL, 32'h0);
    apb(1'b1, OFS_COUNT_LOW, 32'hfe);
    apb(1'b1, OFS_COUNT_HIGH, 32'hff);
    apb(1'b1, OFS_IRQ, 32'he);
    apb(1'b1, OFS_CONTROL, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_IRQ, 32'h0);
    chk("flag set", rv, 32'hf);
    chk("irq", events.irq, 32'h1);
    chk("wake", events.wake, 32'h1);
    apb(1'b1, OFS_IRQ, 32'h7);
    repeat (3) @(posedge pclk);
    apb(1'b0, OFS_IRQ, 32'h0);
    chk("flag kept", rv, 32'h7);
    chk("irq masked", events.irq, 32'h0);
    chk("wake kept", events.wake, 32'h1);
    apb(1'b1, OFS_IRQ, 32'h6);
    repeat (3) @(posedge pclk);
    apb(1'b0, OFS_IRQ, 32'h0);
    chk("flag cleared", rv, 32'h6);
    chk("wake off", events.wake, 32'h0);
  endtask
  task automatic t_special();
    int hits;
    hits = 0;
    apb(1'b1, OFS_CONTROL, 32'h0);
    apb(1'b1, OFS_COUNT_LOW, 32'h0);
    apb(1'b1, OFS_COUNT_HIGH, 32'h0);
    apb(1'b1, OFS_CAPCMP, 32'h10);
    apb(1'b1, OFS_CAPCMP_CTRL, 32'h3);
    apb(1'b1, OFS_AUX_CONTROL, 32'h2);
    apb(1'b1, OFS_CONTROL, 32'h1);
    repeat (100) begin
      @(posedge pclk);
      if (events.compare_event === 1'b1) hits++;
    end
    apb(1'b1, OFS_CONTROL, 32'h0);
    chk("compare hits", 32'(hits >= 5), 32'h1);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    chk("period bound", 32'(rv <= 32'h10), 32'h1);
    apb(1'b0, OFS_IRQ, 32'h0);
    chk("no flag", rv, 32'h6);
  endtask
  task automatic t_capture();
    apb(1'b1, OFS_CAPCMP_CTRL, 32'h1);
    apb(1'b1, OFS_COUNT_LOW, 32'h34);
    apb(1'b1, OFS_COUNT_HIGH, 32'h12);
    u_far.capture();
    apb(1'b0, OFS_CAPCMP, 32'h0);
    chk("capture", rv, 32'h1234);
  endtask
  task automatic t_ext();
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, OFS_CONTROL, 32'h0);
      apb(1'b1, OFS_COUNT_LOW, 32'h0);
      apb(1'b1, OFS_COUNT_HIGH, 32'h0);
      apb(1'b1, OFS_CONTROL, {29'h0, s[0], 2'h3});
      u_far.pulses(5);
      repeat (8) @(posedge pclk);
      apb(1'b0, OFS_COUNT_LOW, 32'h0);
      chk("external count", rv, 32'h4);
    end
    apb(1'b1, OFS_CONTROL, 32'h0);
  endtask
  // Counting halts while the clock enable is low
  task automatic t_freeze();
    logic [7:0] a;
    apb(1'b1, OFS_AUX_CONTROL, 32'h2);
    apb(1'b1, OFS_CONTROL, 32'h1);
    repeat (8) @(posedge pclk);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    a = rv[7:0];
    repeat (10) @(posedge pclk);
    clk_en <= 1'b0;
    repeat (32) @(posedge pclk);
    clk_en <= 1'b1;
    repeat (19) @(posedge pclk);
    apb(1'b0, OFS_COUNT_LOW, 32'h0);
    chk("frozen count", {24'h0, rv[7:0] - a}, 32'h20);
    apb(1'b1, OFS_CONTROL, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rates();
    t_gate();
    t_ovf();
    t_special();
    t_capture();
    t_ext();
    t_freeze();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    conclude();
  end
endmodule
